// ===== inc/flash_protect_defs.svh
// constants for the flash erase and protection logic
// assumes word-addressed flash of 32-bit words, one clock domain
`ifndef FLASH_PROTECT_DEFS_SVH
`define FLASH_PROTECT_DEFS_SVH

`define FP_FLASH_KB        128
`define FP_UNIT_KB         1
`define FP_REGION_KB       2
`define FP_WORD_BYTES      4
`define FP_ERASED_WORD     32'hffffffff
`define FP_DENIED_WORD     32'h00000000
`define FP_UNIT_WORDS      (`FP_UNIT_KB * 1024 / `FP_WORD_BYTES)
`define FP_REGION_UNITS    (`FP_REGION_KB / `FP_UNIT_KB)

`endif

// ===== inc/flash_protect_pkg.sv
// types for the flash erase and protection logic
// assumes the defs header supplies every number
package flash_protect_pkg;

    // protection level of one region
    typedef enum logic [1:0] {
        prot_open      = 2'h0,
        prot_read_only = 2'h1,
        prot_exec_only = 2'h2
    } prot_level_t;

    // controller state, one-hot
    typedef enum logic [1:0] {
        st_idle  = 2'h1,
        st_erase = 2'h2
    } fsm_state_t;

endpackage

// ===== src/flash_block_erase_protect.sv
// flash array with per-unit erase and per-region protection
// assumes requests come from same-clock bus logic, one at a time per port
`include "flash_protect_defs.svh"

// Functional notes
// [RULE_01] flash split into independent erase units
// [RULE_02] erase sets every unit bit to one
// [RULE_03] protection per pair of adjacent units
// [RULE_04] regions settable read-only or execute-only
// [RULE_05] read-only region refuses erase and program
// [RULE_06] execute-only region refuses erase and program
// [RULE_07] execute-only serves instruction fetches only
// [RULE_08] refused access returns zero, flags violation
module flash_block_erase_protect #(
    parameter int FLASH_KB  = `FP_FLASH_KB,
    parameter int ADDR_W    = 15
) (
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,
    input  wire logic                 read_in,
    input  wire logic                 fetch_in,
    input  wire logic                 debug_in,
    input  wire logic [ADDR_W-1:0]    read_addr_in,
    output logic      [31:0]          read_data_out,
    output logic                      read_valid_out,
    input  wire logic                 program_in,
    input  wire logic                 erase_in,
    input  wire logic [ADDR_W-1:0]    write_addr_in,
    input  wire logic [31:0]          write_data_in,
    input  wire logic                 prot_write_in,
    input  wire logic [ADDR_W-1:0]    prot_addr_in,
    input  wire logic [1:0]           prot_level_in,
    output logic                      busy_out,
    output logic                      done_out,
    output logic                      violation_out,
    input  wire logic                 violation_clear_in
);

    localparam int WORDS   = FLASH_KB * 1024 / `FP_WORD_BYTES;
    localparam int UNIT_W  = `FP_UNIT_WORDS;
    localparam int UNITS   = WORDS / UNIT_W;
    localparam int REGIONS = UNITS / `FP_REGION_UNITS;
    localparam int OFF_W   = $clog2(UNIT_W);

    // elaboration check: the address must span whole regions exactly
    if (WORDS != (1 << ADDR_W) || UNITS % `FP_REGION_UNITS != 0) begin
        $error("flash size and address width disagree");
    end

    // *****************************************************************
    // storage and state
    // *****************************************************************
    logic [31:0]                     mem_reg [WORDS];
    flash_protect_pkg::prot_level_t  prot_reg [REGIONS];
    flash_protect_pkg::fsm_state_t   state_reg;
    logic [ADDR_W-1:0]               erase_ptr_reg;
    logic [OFF_W-1:0]                erase_cnt_reg;

    function automatic int region_of(input logic [ADDR_W-1:0] a);
        return int'(a) / (UNIT_W * `FP_REGION_UNITS);
    endfunction

    function automatic logic write_locked(input flash_protect_pkg::prot_level_t p);
        return p != flash_protect_pkg::prot_open;
    endfunction

    // *****************************************************************
    // decode
    // *****************************************************************
    wire idle_w = state_reg == flash_protect_pkg::st_idle;
    // [RULE_03] region from address pair
    wire flash_protect_pkg::prot_level_t wr_prot_w = prot_reg[region_of(write_addr_in)];
    wire flash_protect_pkg::prot_level_t rd_prot_w = prot_reg[region_of(read_addr_in)];
    // [RULE_05] [RULE_06] locked regions refuse writes
    wire wr_req_w    = (program_in | erase_in) & idle_w;
    wire wr_refuse_w = wr_req_w & write_locked(wr_prot_w);
    wire prog_ok_w   = program_in & idle_w & ~write_locked(wr_prot_w);
    // program wins when both strobes arrive together
    wire erase_ok_w  = erase_in & ~program_in & idle_w & ~write_locked(wr_prot_w);
    // [RULE_07] only fetches, never debug, see exec-only
    wire rd_refuse_w = read_in & (rd_prot_w == flash_protect_pkg::prot_exec_only) & (~fetch_in | debug_in);
    wire erase_end_w = state_reg == flash_protect_pkg::st_erase && erase_cnt_reg == OFF_W'(UNIT_W - 1);
    wire [ADDR_W-1:0] unit_base_w = {write_addr_in[ADDR_W-1:OFF_W], OFF_W'(0)};

    // *****************************************************************
    // erase sequencer: one word per cycle
    // *****************************************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_reg     <= flash_protect_pkg::st_idle;
            erase_ptr_reg <= '0;
            erase_cnt_reg <= '0;
        end else begin
            case (state_reg)
                flash_protect_pkg::st_idle: begin
                    if (erase_ok_w) begin
                        state_reg     <= flash_protect_pkg::st_erase;
                        erase_ptr_reg <= unit_base_w;
                        erase_cnt_reg <= '0;
                    end
                end
                // program and erase requests arriving mid-erase are dropped without a flag
                flash_protect_pkg::st_erase: begin
                    erase_cnt_reg <= erase_cnt_reg + OFF_W'(1);
                    if (erase_end_w)
                        state_reg <= flash_protect_pkg::st_idle;
                end
                default: state_reg <= flash_protect_pkg::st_idle;
            endcase
        end
    end

    // program can only clear bits, as a real cell does
    // [RULE_01] [RULE_02] only the chosen unit turns to ones
    always_ff @(posedge mclk_in) begin
        if (state_reg == flash_protect_pkg::st_erase)
            mem_reg[{erase_ptr_reg[ADDR_W-1:OFF_W], erase_cnt_reg}] <= `FP_ERASED_WORD;
        else if (prog_ok_w)
            mem_reg[write_addr_in] <= mem_reg[write_addr_in] & write_data_in;
    end

    // no unlock short of reset, so a stray write cannot open a region
    // [RULE_04] per-region level, sticky once set
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            for (int i = 0; i < REGIONS; i++)
                prot_reg[i] <= flash_protect_pkg::prot_open;
        end else if (prot_write_in && prot_level_in != 2'h0 && prot_level_in != 2'h3
                     && prot_reg[region_of(prot_addr_in)] == flash_protect_pkg::prot_open) begin
            prot_reg[region_of(prot_addr_in)] <= flash_protect_pkg::prot_level_t'(prot_level_in);
        end
    end

    // *****************************************************************
    // outputs
    // *****************************************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            read_data_out  <= `FP_DENIED_WORD;
            read_valid_out <= 1'b0;
            busy_out       <= 1'b0;
            done_out       <= 1'b0;
            violation_out  <= 1'b0;
        end else begin
            read_valid_out <= read_in;
            // [RULE_08] denied read returns zero
            read_data_out  <= rd_refuse_w ? `FP_DENIED_WORD : mem_reg[read_addr_in];
            busy_out       <= erase_ok_w | (state_reg == flash_protect_pkg::st_erase && !erase_end_w);
            done_out       <= erase_end_w | prog_ok_w;
            // [RULE_08] sticky flag, set beats clear
            violation_out  <= wr_refuse_w | rd_refuse_w | (violation_out & ~violation_clear_in);
        end
    end

    // *****************************************************************
    // check helpers
    // *****************************************************************
    // own count of erase cycles, so the sequencer's counter
    // is not trusted to judge itself
    logic [OFF_W:0]                  erase_len_reg;

    always_ff @(posedge mclk_in) begin
        if (reset_in || state_reg != flash_protect_pkg::st_erase)
            erase_len_reg <= '0;
        else
            erase_len_reg <= erase_len_reg + (OFF_W+1)'(1);
    end

    // *****************************************************************
    // checks
    // *****************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    // write protection
    refused_write_flag_a: assert property (wr_refuse_w |=> violation_out) // [RULE_05]
        else $error("refused write did not flag");
    locked_no_prog_a: assert property (wr_refuse_w |=> !done_out && !busy_out) // [RULE_06]
        else $error("locked region accepted a write");

    // read side
    exec_data_zero_a: assert property (rd_refuse_w |=> read_data_out == `FP_DENIED_WORD && violation_out) // [RULE_07]
        else $error("data read of exec-only region leaked");
    fetch_served_a: assert property ( // [RULE_07]
        read_in && fetch_in && !debug_in |=> read_data_out == $past(mem_reg[read_addr_in]))
        else $error("instruction fetch not served");
    read_only_data_a: assert property ( // [RULE_05]
        read_in && rd_prot_w == flash_protect_pkg::prot_read_only |=> read_data_out == $past(mem_reg[read_addr_in]))
        else $error("read of read-only region refused");
    region_pair_a: assert property (rd_prot_w == prot_reg[read_addr_in[ADDR_W-1:OFF_W+1]]) // [RULE_03]
        else $error("region map wrong");

    // erase
    erase_length_a: assert property ( // [RULE_01]
        $rose(state_reg == flash_protect_pkg::st_erase) |-> (state_reg == flash_protect_pkg::st_erase) [*8])
        else $error("erase ended too early");
    erase_full_a: assert property ( // [RULE_01]
        state_reg == flash_protect_pkg::st_erase |-> erase_len_reg <= (OFF_W+1)'(UNIT_W - 1)
            && erase_end_w == (erase_len_reg == (OFF_W+1)'(UNIT_W - 1)))
        else $error("erase does not cover the whole unit");
    busy_while_erase_a: assert property (state_reg == flash_protect_pkg::st_erase |-> busy_out) // [RULE_01]
        else $error("busy low during erase");
    erase_ones_a: assert property ( // [RULE_02]
        state_reg == flash_protect_pkg::st_erase
        |=> mem_reg[$past({erase_ptr_reg[ADDR_W-1:OFF_W], erase_cnt_reg})] == `FP_ERASED_WORD)
        else $error("erased word not all ones");
    erase_done_a: assert property (erase_end_w |=> done_out && !busy_out) // [RULE_02]
        else $error("erase end not reported");

    // levels and flag
    level_sticky_a: assert property ( // [RULE_04]
        prot_reg[0] != flash_protect_pkg::prot_open |=> $stable(prot_reg[0]))
        else $error("protection level changed");
    flag_hold_a: assert property (violation_out && !violation_clear_in |=> violation_out) // [RULE_08]
        else $error("violation flag dropped");
    flag_clear_a: assert property (violation_clear_in && !wr_refuse_w && !rd_refuse_w |=> !violation_out) // [RULE_08]
        else $error("violation flag not cleared");

    erase_seen_c: cover property (erase_end_w);
    fetch_exec_c: cover property (read_in && fetch_in && !debug_in && rd_prot_w == flash_protect_pkg::prot_exec_only);
    debug_deny_c: cover property (rd_refuse_w && debug_in);
    wr_refuse_c:  cover property (wr_refuse_w);
    lock_read_c:  cover property (read_in && rd_prot_w == flash_protect_pkg::prot_read_only);

endmodule

// ===== sim/bus_partner.sv
// request side: processor buses and debugger
// assumes the bench calls req and samples flash outputs
module bus_partner (
    input  wire logic   mclk_in,
    output logic        rd_out,
    output logic        fetch_out,
    output logic        dbg_out,
    output logic        prog_out,
    output logic        erase_out,
    output logic        prot_out,
    output logic        clr_out,
    output logic [14:0] addr_out,
    output logic [31:0] data_out,
    output logic [1:0]  level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // driver
    // ************
    initial {rd_out, fetch_out, dbg_out, prog_out, erase_out, prot_out, clr_out, addr_out, data_out, level_out} = 56'h0;
    // address and data lines scrambled once released, so stale values never help
    task automatic req(input int k, input logic [14:0] a, input logic [31:0] d, input logic [1:0] m);
        @(posedge mclk_in);
        {rd_out, prog_out, erase_out, prot_out, clr_out} <= 5'h10 >> k;
        {dbg_out, fetch_out, level_out, addr_out, data_out} <= {m, m, a, d};
        @(posedge mclk_in);
        {rd_out, prog_out, erase_out, prot_out, clr_out} <= 5'h0;
        {addr_out, data_out} <= {~a, ~d};
    endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for flash erase and protection
// assumes bus_partner drives every request input
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        rd, fetch, dbg, prog, erase, prot, clr, rvalid, busy, done, viol;
    logic [14:0] addr;
    logic [31:0] wdata, rdata;
    logic [1:0]  level;
    int          err_count = 0;
    int          tests_run = 0;
    always #2 mclk_in = ~mclk_in;
    bus_partner partner (.mclk_in(mclk_in), .rd_out(rd), .fetch_out(fetch), .dbg_out(dbg), .prog_out(prog),
        .erase_out(erase), .prot_out(prot), .clr_out(clr), .addr_out(addr), .data_out(wdata), .level_out(level));
    flash_block_erase_protect dut (.mclk_in(mclk_in), .reset_in(reset_in), .read_in(rd), .fetch_in(fetch),
        .debug_in(dbg), .read_addr_in(addr), .read_data_out(rdata), .read_valid_out(rvalid), .program_in(prog),
        .erase_in(erase), .write_addr_in(addr), .write_data_in(wdata), .prot_write_in(prot), .prot_addr_in(addr),
        .prot_level_in(level), .busy_out(busy), .done_out(done), .violation_out(viol), .violation_clear_in(clr));
    // ************
    // tasks
    // ************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rd_chk(input logic [14:0] a, input logic [1:0] m, input logic [31:0] exp);
        partner.req(0, a, 32'h0, m);
        #1;
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask
    task automatic prog_chk(input logic [14:0] a, input logic [31:0] d, input logic ok);
        partner.req(1, a, d, 2'h0);
        #1;
        check(done, ok);
    endtask
    // flag is sticky, so look one cycle late, then clear it
    task automatic viol_chk(input logic exp);
        @(posedge mclk_in);
        #1;
        check(viol, exp);
        partner.req(4, 15'h0, 32'h0, 2'h0);
        #1;
        check(viol, 1'b0);
    endtask
    // a refused erase never raises busy
    task automatic erase_chk(input logic [14:0] a, input logic ok);
        int n;
        partner.req(2, a, 32'h0, 2'h0);
        #1;
        n = 0;
        // one edge per word while busy stands
        while (busy === 1'b1 && n < 300) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        check(n, ok ? 256 : 0);
        check(done, ok);
        if (n >= 300) finish_test();
    endtask
    // ************
    // sequence
    // ************
    initial begin
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        erase_chk(15'h0100, 1'b1);
        prog_chk(15'h0100, 32'h0000a5a5, 1'b1);
        erase_chk(15'h0000, 1'b1);
        rd_chk(15'h00ff, 2'h0, 32'hffffffff);
        rd_chk(15'h0100, 2'h0, 32'h0000a5a5);
        erase_chk(15'h0200, 1'b1);
        partner.req(3, 15'h01ff, 32'h0, 2'h1);
        prog_chk(15'h0100, 32'h0, 1'b0);
        viol_chk(1'b1);
        erase_chk(15'h0000, 1'b0);
        viol_chk(1'b1);
        rd_chk(15'h0100, 2'h0, 32'h0000a5a5);
        prog_chk(15'h0200, 32'hffffffff, 1'b1);
        viol_chk(1'b0);
        partner.req(3, 15'h0200, 32'h0, 2'h2);
        rd_chk(15'h02ff, 2'h1, 32'hffffffff);
        rd_chk(15'h0200, 2'h0, 32'h0);
        viol_chk(1'b1);
        rd_chk(15'h0200, 2'h3, 32'h0);
        viol_chk(1'b1);
        erase_chk(15'h0300, 1'b0);
        viol_chk(1'b1);
        prog_chk(15'h0300, 32'h0, 1'b0);
        viol_chk(1'b1);
        // a locked level cannot be changed
        partner.req(3, 15'h0000, 32'h0, 2'h2);
        rd_chk(15'h0100, 2'h0, 32'h0000a5a5);
        viol_chk(1'b0);
        // second reset opens every region again
        @(posedge mclk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        prog_chk(15'h0300, 32'h0, 1'b1);
        rd_chk(15'h0300, 2'h0, 32'h0);
        viol_chk(1'b0);
        finish_test();
    end
endmodule
